// ==== hw/mes_pkg.sv ====
package mes_pkg;

  // ---------------------------------------------------------------
  // register map (indices as printed, byte address is four times)
  // ---------------------------------------------------------------
  localparam int             MES_AW              = 12;
  localparam int             MES_IDX_STYLE_A     = 'h42;
  localparam int             MES_IDX_LENGTH_A    = 'h43;
  localparam int             MES_IDX_RESID_B     = 'h44;
  localparam int             MES_IDX_TYPE_B      = 'h45;
  localparam int             MES_IDX_STATUS      = 'h46;
  localparam int             MES_BYTES_PER_REG   = 4;
  localparam logic [11:0]    MES_ADDR_STYLE_A    = 12'(MES_IDX_STYLE_A * MES_BYTES_PER_REG);
  localparam logic [11:0]    MES_ADDR_LENGTH_A   = 12'(MES_IDX_LENGTH_A * MES_BYTES_PER_REG);
  localparam logic [11:0]    MES_ADDR_RESID_B    = 12'(MES_IDX_RESID_B * MES_BYTES_PER_REG);
  localparam logic [11:0]    MES_ADDR_TYPE_B     = 12'(MES_IDX_TYPE_B * MES_BYTES_PER_REG);
  localparam logic [11:0]    MES_ADDR_STATUS     = 12'(MES_IDX_STATUS * MES_BYTES_PER_REG);

  // ---------------------------------------------------------------
  // field masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]     MES_STYLE_MASK      = 8'h77;
  localparam logic [7:0]     MES_LENGTH_MASK     = 8'h9F;
  localparam logic [7:0]     MES_RST_STYLE       = 8'h00;
  localparam logic [7:0]     MES_RST_LENGTH      = 8'h04;
  localparam logic [7:0]     MES_RST_RESID       = 8'h00;
  localparam logic [7:0]     MES_RST_TYPE        = 8'h11;

  // ---------------------------------------------------------------
  // edge style codes and shaping constants
  // ---------------------------------------------------------------
  localparam logic [3:0]     MES_T_LIN1          = 4'h1;
  localparam logic [3:0]     MES_T_LIN2          = 4'h2;
  localparam logic [3:0]     MES_T_LIN3          = 4'h3;
  localparam logic [3:0]     MES_T_LUT           = 4'h4;
  localparam logic [3:0]     MES_T_LUT_CORR      = 4'h5;
  localparam logic [3:0]     MES_T_LUT_ADAPT     = 4'h6;
  localparam logic [7:0]     MES_FULL            = 8'hFF;
  localparam logic [7:0]     MES_HALF            = 8'h80;
  localparam logic [7:0]     MES_THIRD           = 8'h55;
  localparam logic [7:0]     MES_TWO_THIRD       = 8'hAA;
  localparam logic [7:0]     MES_KNEE_BASE       = 8'h10;
  localparam logic [2:0]     MES_LUT_MAX         = 3'h3;
  localparam logic [7:0]     MES_SUPPLY_NOM      = 8'h80;
  localparam logic [7:0]     MES_SUPPLY_BAND     = 8'h10;

  // ---------------------------------------------------------------
  // axi responses
  // ---------------------------------------------------------------
  localparam logic [1:0]     MES_RESP_OKAY       = 2'h0;
  localparam logic [1:0]     MES_RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    MES_SEL_STYLE, MES_SEL_LENGTH, MES_SEL_RESID, MES_SEL_TYPE, MES_SEL_STATUS, MES_SEL_NONE
  } mes_sel_e;

  // decoded shaper configuration
  typedef struct packed {
    logic [3:0] fall_type;
    logic [3:0] rise_type;
    logic [2:0] fall_sel;
    logic [2:0] rise_sel;
    logic       dbl;
    logic [4:0] states;
    logic [7:0] residual;
  } mes_cfg_s;

endpackage : mes_pkg

// ==== hw/mes_edge_shaper.sv ====
`timescale 1ns/10ps
module mes_edge_shaper
  import mes_pkg::*;
(
  input  wire logic                    sys_clk,         // 125 MHz clock
  input  wire logic                    rstn,            // sync reset, active low
  input  wire logic                    ce,              // clock enable
  input  wire logic [mes_pkg::MES_AW-1:0] s_axi_awaddr, // write address
  input  wire logic                    s_axi_awvalid,   // write address valid
  output logic                         s_axi_awready,   // write address ready
  input  wire logic [31:0]             s_axi_wdata,     // write data
  input  wire logic [3:0]              s_axi_wstrb,     // write strobes
  input  wire logic                    s_axi_wvalid,    // write data valid
  output logic                         s_axi_wready,    // write data ready
  output logic [1:0]                   s_axi_bresp,     // write response
  output logic                         s_axi_bvalid,    // write response valid
  input  wire logic                    s_axi_bready,    // write response ready
  input  wire logic [mes_pkg::MES_AW-1:0] s_axi_araddr, // read address
  input  wire logic                    s_axi_arvalid,   // read address valid
  output logic                         s_axi_arready,   // read address ready
  output logic [31:0]                  s_axi_rdata,     // read data
  output logic [1:0]                   s_axi_rresp,     // read response
  output logic                         s_axi_rvalid,    // read data valid
  input  wire logic                    s_axi_rready,    // read data ready
  input  wire logic                    mod_req,         // pin: high requests modulation
  input  wire logic                    carrier_pin,     // pin: 13.56 MHz carrier
  input  wire logic [7:0]              transmitter_supply_voltage, // pin: supply level
  output logic [7:0]                   amp_out,         // shaped carrier amplitude
  output logic                         edge_busy,       // an edge is in progress
  output logic                         in_residual      // residual level reached
);
  import mes_pkg::*;

  typedef enum logic [1:0] {MES_IDLE, MES_FALL, MES_HOLD, MES_RISE} mes_state_e;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic mes_sel_e mes_decode(input logic [MES_AW-1:0] addr);
    mes_sel_e s;
    s = MES_SEL_NONE;
    case (addr)
      MES_ADDR_STYLE_A:  s = MES_SEL_STYLE;
      MES_ADDR_LENGTH_A: s = MES_SEL_LENGTH;
      MES_ADDR_RESID_B:  s = MES_SEL_RESID;
      MES_ADDR_TYPE_B:   s = MES_SEL_TYPE;
      MES_ADDR_STATUS:   s = MES_SEL_STATUS;
      default:           s = MES_SEL_NONE;
    endcase
    return s;
  endfunction : mes_decode

  // scale a span by p/255
  function automatic logic [7:0] mes_scale(input logic [7:0] span, input logic [7:0] p);
    logic [15:0] prod;
    prod = 16'(span) * 16'(p);
    return 8'(prod / 16'(MES_FULL));
  endfunction : mes_scale

  // piecewise segment from (x0,y0) to (x0+w,y1)
  function automatic logic [7:0] mes_seg(input logic [7:0] y0, input logic [7:0] y1,
                                         input logic [7:0] dx, input logic [7:0] w);
    logic [15:0] prod;
    prod = 16'(y1 - y0) * 16'(dx);
    return 8'(16'(y0) + prod / 16'(w));
  endfunction : mes_seg

  // firmware styles: knee level set by the time constant
  function automatic logic [7:0] mes_fw(input logic [3:0] t, input logic [2:0] tc,
                                        input logic [7:0] p);
    logic [7:0] kp;
    logic [7:0] kh;
    kp = 8'({tc, 5'h00}) + MES_KNEE_BASE;
    kh = kp >> 1;
    if (t == MES_T_LIN2) begin
      if (p < MES_HALF) return mes_seg(8'h00, kp, p, MES_HALF);
      return mes_seg(kp, MES_FULL, p - MES_HALF, MES_FULL - MES_HALF);
    end else if (t == MES_T_LIN3) begin
      if (p < MES_THIRD) return mes_seg(8'h00, kh, p, MES_THIRD);
      if (p < MES_TWO_THIRD) return mes_seg(kh, kp, p - MES_THIRD, MES_THIRD);
      return mes_seg(kp, MES_FULL, p - MES_TWO_THIRD, MES_FULL - MES_TWO_THIRD);
    end
    return p;
  endfunction : mes_fw

  // lookup tables 0..3
  function automatic logic [7:0] mes_lut(input logic [2:0] idx, input logic [7:0] p);
    logic [15:0] sq;
    logic [15:0] isq;
    sq  = 16'(p) * 16'(p);
    isq = 16'(MES_FULL - p) * 16'(MES_FULL - p);
    case (idx)
      3'd0:    return p;
      3'd1:    return sq[15:8];
      3'd2:    return MES_FULL - isq[15:8];
      default: return (p < MES_HALF) ? sq[14:7] : MES_FULL - isq[14:7];
    endcase
  endfunction : mes_lut

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic       mod_s1, mod_s2;
  logic       car_s1, car_s2, car_s3;
  logic [7:0] sup_s1, sup_s2;

  // two flops per pin, one more for carrier edge detect
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {mod_s1, mod_s2, car_s1, car_s2, car_s3} <= 5'h00;
      sup_s1 <= MES_SUPPLY_NOM;
      sup_s2 <= MES_SUPPLY_NOM;
    end else if (ce) begin
      mod_s1 <= mod_req;
      mod_s2 <= mod_s1;
      car_s1 <= carrier_pin;
      car_s2 <= car_s1;
      car_s3 <= car_s2;
      sup_s1 <= transmitter_supply_voltage;
      sup_s2 <= sup_s1;
    end
  end

  logic car_tick;
  assign car_tick = car_s2 & ~car_s3; // one per carrier cycle

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0] style_a, length_a, resid_b, type_b;
  mes_cfg_s   cfg;

  // whole struct in one assignment, one driver for cfg
  assign cfg = {type_b[7:4],
                type_b[3:0],
                style_a[6:4],
                style_a[2:0],
                length_a[7],
                length_a[4:0],
                resid_b};

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic [MES_AW-1:0] aw_addr;
  logic              aw_held, w_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  mes_sel_e          wsel;

  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wsel     = mes_decode(aw_addr);

  // write address and data taken in either order, response after both
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= MES_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == MES_SEL_NONE) ? MES_RESP_SLVERR : MES_RESP_OKAY;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // register update, reserved bits forced to zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      style_a  <= MES_RST_STYLE;
      length_a <= MES_RST_LENGTH;
      resid_b  <= MES_RST_RESID;
      type_b   <= MES_RST_TYPE;
    end else if (ce && do_write && w_strb[0]) begin
      case (wsel)
        MES_SEL_STYLE:  style_a  <= w_data[7:0] & MES_STYLE_MASK;
        MES_SEL_LENGTH: length_a <= w_data[7:0] & MES_LENGTH_MASK;
        MES_SEL_RESID:  resid_b  <= w_data[7:0];
        MES_SEL_TYPE:   type_b   <= w_data[7:0];
        default:        ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // edge sequencer
  // ---------------------------------------------------------------
  mes_state_e st;
  logic [4:0] step;
  logic       phase;
  logic       step_adv;
  logic       last_step;

  assign step_adv  = car_tick & (~cfg.dbl | phase);
  assign last_step = (5'(step + 5'd1) >= cfg.states);

  // full -> residual -> full, one transition state per step
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st    <= MES_IDLE;
      step  <= 5'd0;
      phase <= 1'b0;
    end else if (ce) begin
      case (st)
        MES_IDLE: begin
          step  <= 5'd0;
          phase <= 1'b0;
          if (mod_s2) st <= (cfg.states == 5'd0) ? MES_HOLD : MES_FALL;
        end
        MES_FALL, MES_RISE: begin
          if (car_tick) phase <= cfg.dbl & ~phase;
          if (step_adv) begin
            step <= 5'(step + 5'd1);
            if (last_step) begin
              st   <= (st == MES_FALL) ? MES_HOLD : MES_IDLE;
              step <= 5'd0;
            end
          end
        end
        MES_HOLD: begin
          step  <= 5'd0;
          phase <= 1'b0;
          if (!mod_s2) st <= (cfg.states == 5'd0) ? MES_IDLE : MES_RISE;
        end
        default: st <= MES_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // shape evaluation
  // ---------------------------------------------------------------
  logic [3:0] cur_type;
  logic [2:0] cur_sel, eff_sel;
  logic       cur_lut, cur_fw;
  logic [7:0] prog, frac, corr, span, next_amp;
  logic [9:0] prog_num;
  logic       sup_hi, sup_lo;

  assign cur_type = (st == MES_RISE) ? cfg.rise_type : cfg.fall_type;
  assign cur_sel  = (st == MES_RISE) ? cfg.rise_sel : cfg.fall_sel;
  assign cur_fw   = (cur_type >= MES_T_LIN1) && (cur_type <= MES_T_LIN3);
  assign cur_lut  = (cur_type >= MES_T_LUT) && (cur_type <= MES_T_LUT_ADAPT);
  assign prog_num = 10'(step) * 10'(MES_FULL);
  assign prog     = (cfg.states == 5'd0) ? MES_FULL : 8'(prog_num / 10'(cfg.states));
  assign sup_hi   = sup_s2 > (MES_SUPPLY_NOM + MES_SUPPLY_BAND);
  assign sup_lo   = sup_s2 < (MES_SUPPLY_NOM - MES_SUPPLY_BAND);
  assign span     = MES_FULL - cfg.residual;

  // table choice and supply adaptation
  always_comb begin
    eff_sel = (cur_sel > MES_LUT_MAX) ? MES_LUT_MAX : cur_sel;
    corr    = 8'h00;
    if (cur_type == MES_T_LUT_CORR || cur_type == MES_T_LUT_ADAPT) begin
      if (sup_hi && eff_sel != MES_LUT_MAX) eff_sel = 3'(eff_sel + 3'd1);
      else if (sup_lo && eff_sel != 3'd0) eff_sel = 3'(eff_sel - 3'd1);
    end
    if (cur_type == MES_T_LUT_CORR) corr = (sup_s2 >> 3) ^ (MES_SUPPLY_NOM >> 3);
  end

  // progress fraction by style; reserved codes switch hard
  always_comb begin
    if (cur_fw) frac = mes_fw(cur_type, cur_sel, prog);
    else if (cur_lut) frac = mes_lut(eff_sel, prog);
    else frac = MES_FULL;
  end

  // amplitude target for this cycle
  always_comb begin
    case (st)
      MES_FALL: next_amp = MES_FULL - mes_scale(span, frac);
      MES_RISE: next_amp = cfg.residual + mes_scale(span, frac);
      MES_HOLD: next_amp = cfg.residual;
      default:  next_amp = MES_FULL;
    endcase
    if (st == MES_FALL || st == MES_RISE) begin
      if (sup_hi && next_amp > corr) next_amp = next_amp - corr;
      else if (sup_lo && next_amp < MES_FULL - corr) next_amp = next_amp + corr;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      amp_out     <= MES_FULL;
      edge_busy   <= 1'b0;
      in_residual <= 1'b0;
    end else if (ce) begin
      amp_out     <= next_amp;
      edge_busy   <= (st == MES_FALL) || (st == MES_RISE);
      in_residual <= (st == MES_HOLD);
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= MES_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= MES_RESP_OKAY;
        case (mes_decode(s_axi_araddr))
          MES_SEL_STYLE:  s_axi_rdata <= {24'h000000, style_a};
          MES_SEL_LENGTH: s_axi_rdata <= {24'h000000, length_a};
          MES_SEL_RESID:  s_axi_rdata <= {24'h000000, resid_b};
          MES_SEL_TYPE:   s_axi_rdata <= {24'h000000, type_b};
          MES_SEL_STATUS: s_axi_rdata <= {16'h0000, edge_busy, in_residual, 1'b0, step, amp_out};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= MES_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [1:0] ticks_since;

  // carrier cycles seen since the last step advance
  always_ff @(posedge sys_clk) begin
    if (!rstn || st == MES_IDLE || st == MES_HOLD) ticks_since <= 2'd0;
    else if (ce && step_adv) ticks_since <= 2'd0;
    else if (ce && car_tick && ticks_since != 2'd3) ticks_since <= 2'(ticks_since + 2'd1);
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  fall_sel_used_a: assert property ((st == MES_FALL) |-> cur_sel == style_a[6:4])
    else $error("falling edge not using style bits 6..4");
  rise_sel_used_a: assert property ((st == MES_RISE) |-> cur_sel == style_a[2:0])
    else $error("rising edge not using style bits 2..0");
  field_meaning_a: assert property (cur_lut == (type_b[7:4] inside {4'h4, 4'h5, 4'h6})
                                    || st == MES_RISE)
    else $error("style field meaning wrong for type code");
  state_dwell_a: assert property ((ce && step_adv && st != MES_IDLE)
                                  |-> ticks_since == (cfg.dbl ? 2'd1 : 2'd0))
    else $error("transition state length wrong");
  state_count_a: assert property ((ce && st == MES_FALL && step_adv && last_step)
                                  |=> st == MES_HOLD && $past(step) == 5'(cfg.states - 5'd1))
    else $error("edge length not equal to configured states");
  residual_hold_a: assert property ((ce && st == MES_HOLD) ##1 ce |-> amp_out == $past(resid_b))
    else $error("residual level not held");
  linear_one_a: assert property ((cur_type == MES_T_LIN1) |-> frac == prog)
    else $error("single linear style not linear");
  lut_plain_a: assert property ((cur_type == MES_T_LUT) |-> eff_sel == 3'(cur_sel > 3'd3 ? 3'd3
                                : cur_sel) && corr == 8'h00)
    else $error("plain table adapted to supply");
  adapt_nocorr_a: assert property ((cur_type == MES_T_LUT_ADAPT) |-> corr == 8'h00)
    else $error("correction applied without request");
  rise_nibble_a: assert property ((st == MES_RISE) |-> cur_type == type_b[3:0])
    else $error("rising edge not using low nibble");
  idle_full_a: assert property ((ce && st == MES_IDLE && !mod_s2) ##1 ce
                                |-> amp_out == 8'hFF && !edge_busy)
    else $error("idle output not full carrier");
  edge_start_a: assert property ((ce && st == MES_IDLE && mod_s2 && cfg.states != 5'd0)
                                 |=> st == MES_FALL && step == 5'd0)
    else $error("falling edge did not start");

endmodule : mes_edge_shaper

// ==== bench/mes_edge_shaper_test.sv ====
`timescale 1ns/10ps
module mes_edge_shaper_test;
  import mes_pkg::*;
  logic        sys_clk, rstn, ce, mod_req, carrier_pin;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cdiv, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  supply, amp_out;
  logic        edge_busy, in_residual;
  logic [31:0] d;
  int          n_errors, cmp_count, cyc;
  logic [11:0] adr [4] = '{MES_ADDR_STYLE_A, MES_ADDR_LENGTH_A, MES_ADDR_RESID_B, MES_ADDR_TYPE_B};
  logic [7:0]  rst [4] = '{MES_RST_STYLE, MES_RST_LENGTH, MES_RST_RESID, MES_RST_TYPE};

  mes_edge_shaper uut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mod_req(mod_req),
    .carrier_pin(carrier_pin), .transmitter_supply_voltage(supply), .amp_out(amp_out),
    .edge_busy(edge_busy), .in_residual(in_residual));

  // clock, 8 ns period
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // carrier stand-in: one carrier cycle every 8 clocks; timeout counter
  always @(posedge sys_clk) begin
    cdiv <= cdiv + 2'h1;
    if (cdiv == 2'h3) carrier_pin <= ~carrier_pin;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // axi write: each channel released when taken, response awaited
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] w, output logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_wr

  // axi read
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] q, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_rd

  // one modulation pulse: fall length in carrier cycles, residual hold, rise back
  task automatic shape(input logic [7:0] len, input logic [7:0] typ, input int ticks);
    int         n;
    logic [7:0] prev;
    axi_wr(MES_ADDR_LENGTH_A, {24'h0, len}, r);
    axi_wr(MES_ADDR_TYPE_B, {24'h0, typ}, r);
    mod_req <= 1'b1;
    n = 0;
    prev = MES_FULL;
    while (in_residual !== 1'b1 && n < 500) begin
      @(posedge sys_clk);
      if (edge_busy === 1'b1) n++;
      chk(32'(amp_out > prev), 32'h0, "fall_step");
      prev = amp_out;
    end
    chk(32'(n >= ticks * 8 - 8 && n <= ticks * 8 + 4), 32'h1, "fall_cycles");
    repeat (2) @(posedge sys_clk);
    chk(amp_out, 32'h40, "residual_level");
    mod_req <= 1'b0;
    repeat (6) @(posedge sys_clk);
    n = 0;
    while ((edge_busy !== 1'b0 || in_residual !== 1'b0) && n < 500) begin
      @(posedge sys_clk);
      n++;
      chk(32'(amp_out < prev), 32'h0, "rise_step");
      prev = amp_out;
    end
    repeat (2) @(posedge sys_clk);
    chk(amp_out, MES_FULL, "full_after_rise");
  endtask : shape

  initial begin
    {rstn, mod_req, carrier_pin, cdiv, cyc, n_errors, cmp_count} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    supply = MES_SUPPLY_NOM;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk(amp_out, MES_FULL, "amp_reset");
    for (int i = 0; i < 4; i++) begin
      axi_rd(adr[i], d, r);
      chk(d, {24'h0, rst[i]}, "reset_value");
    end
    axi_rd(MES_ADDR_STATUS, d, r);
    chk(d, 32'h000000FF, "status_reset");
    // reserved bits read back zero
    axi_wr(MES_ADDR_STYLE_A, 32'hFF, r);
    axi_rd(MES_ADDR_STYLE_A, d, r);
    chk(d, 32'h77, "style_fields");
    axi_wr(MES_ADDR_LENGTH_A, 32'hFF, r);
    axi_rd(MES_ADDR_LENGTH_A, d, r);
    chk(d, 32'h9F, "length_fields");
    // every listed style code in both nibbles
    for (int c = 1; c <= 6; c++) begin
      axi_wr(MES_ADDR_TYPE_B, {24'h0, 4'(c), 4'(c)}, r);
      axi_rd(MES_ADDR_TYPE_B, d, r);
      chk(d, {24'h0, 4'(c), 4'(c)}, "type_code");
    end
    // unmapped place refused
    axi_wr(12'hFFC, 32'h5A, r);
    chk(r, MES_RESP_SLVERR, "unmapped_wr");
    axi_rd(12'hFFC, d, r);
    chk({d, r}, {32'h0, MES_RESP_SLVERR}, "unmapped_rd");
    axi_wr(MES_ADDR_RESID_B, 32'h40, r);
    axi_rd(MES_ADDR_RESID_B, d, r);
    chk(d, 32'h40, "residual_rw");
    // write with byte strobe off leaves the register alone
    s_axi_wstrb <= 4'h0;
    axi_wr(MES_ADDR_RESID_B, 32'h11, r);
    s_axi_wstrb <= 4'hF;
    axi_rd(MES_ADDR_RESID_B, d, r);
    chk(d, 32'h40, "strobe_off");
    axi_wr(MES_ADDR_STYLE_A, 32'h21, r);
    // clock enable low freezes the sequencer
    ce <= 1'b0;
    mod_req <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk(edge_busy, 1'b0, "ce_freeze_busy");
    chk(amp_out, MES_FULL, "ce_freeze_amp");
    mod_req <= 1'b0;
    @(posedge sys_clk);
    ce <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(edge_busy, 1'b0, "ce_resume_idle");
    shape(8'h02, 8'h11, 2);
    shape(8'h82, 8'h22, 4);
    shape(8'h05, 8'h33, 5);
    shape(8'h03, 8'h44, 3);
    shape(8'h83, 8'h55, 6);
    shape(8'h03, 8'h66, 3);
    shape(8'h00, 8'h16, 0);
    end_sim();
  end
endmodule : mes_edge_shaper_test
